// ===== hw/dvam_params.svh
// Register offsets, field positions, reset values and timing counts of the volume block
// Contract
// R1: Left mutes after selected zero-run length
// R2: Right mutes after selected zero-run length
// R3: Mute times counted in samples, scale
// R4: Link 00: channels use own codes
// R5: Link 01: right follows left code
// R6: Left code: 0 is +24dB, 0.5dB steps
// R7: Right code same scale, reset unity
// R8: FE is -103dB, FF is mute
// R9: Ramp-down every 1/2 samples, 11 instant; code also updates every 4 samples for 10
// R10: Ramp-down step 4/2/1 dB per update
// R11: Ramp-up every 1/2/4 samples, 11 instant
// R12: Right writes stored, unused while linked
`ifndef DVAM_PARAMS_SVH
`define DVAM_PARAMS_SVH
//------------------------------------------------------------
// Register offsets
//------------------------------------------------------------
`define DVAM_OFS_AMT 8'h3B
`define DVAM_OFS_LINK 8'h3C
`define DVAM_OFS_LVOL 8'h3D
`define DVAM_OFS_RVOL 8'h3E
`define DVAM_OFS_RAMP 8'h3F
//------------------------------------------------------------
// Reset values
//------------------------------------------------------------
`define DVAM_RST_AMT 8'h00
`define DVAM_RST_LINK 8'h00
`define DVAM_RST_VOL 8'h30
`define DVAM_RST_RAMP 8'h33
//------------------------------------------------------------
// Field positions and codes
//------------------------------------------------------------
`define DVAM_LEFT_ZERO_MUTE_TIME_LSB 4
`define DVAM_RIGHT_ZERO_MUTE_TIME_LSB 0
`define DVAM_AMT_MASK 8'h77
`define DVAM_LINK_MASK 8'h03
`define DVAM_LINK_FOLLOW 2'h1
`define DVAM_VOL_MUTE 8'hFF
`define DVAM_VOL_MIN 8'hFE
`define DVAM_RATE_INSTANT 2'h3
//------------------------------------------------------------
// Zero-run lengths in samples at 48 kHz (ms * 48)
//------------------------------------------------------------
`define DVAM_ZRUN_0 20'h00450
`define DVAM_ZRUN_1 20'h013E0
`define DVAM_ZRUN_2 20'h027F0
`define DVAM_ZRUN_3 20'h063F0
`define DVAM_ZRUN_4 20'h0C8A0
`define DVAM_ZRUN_5 20'h18F60
`define DVAM_ZRUN_6 20'h3E760
`define DVAM_ZRUN_7 20'h7CEC0
`endif

// ===== hw/dvam_pkg.sv
// Types shared by the volume and auto-mute block
package dvam_pkg;
    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dvam_req_s;
    // One stereo sample with its strobe
    typedef struct packed {
        logic valid;
        logic [23:0] left;
        logic [23:0] right;
    } dvam_smp_s;
    // Ramp state of one channel
    typedef enum logic [1:0] {
        DVAM_ST_RUN,
        DVAM_ST_DOWN,
        DVAM_ST_MUTED,
        DVAM_ST_UP
    } dvam_ramp_e;
endpackage : dvam_pkg

// ===== hw/dvam_chan.sv
// One channel: zero-run auto-mute detector and soft ramp of the live gain code
`include "dvam_params.svh"
module dvam_chan (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fs_tick_in,
    input wire logic zero_in,
    input wire logic soft_mute_in,
    input wire logic [2:0] zrun_sel_in,
    input wire logic [7:0] target_in,
    input wire logic [7:0] ramp_in,
    output logic [7:0] gain_out,
    output logic auto_muted_out
);
    import dvam_pkg::*;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Zero-run length in samples; counting samples makes time scale with rate
    function automatic logic [19:0] zrun_len(input logic [2:0] sel);
        case (sel)
            3'h0: zrun_len = `DVAM_ZRUN_0;
            3'h1: zrun_len = `DVAM_ZRUN_1;
            3'h2: zrun_len = `DVAM_ZRUN_2;
            3'h3: zrun_len = `DVAM_ZRUN_3;
            3'h4: zrun_len = `DVAM_ZRUN_4;
            3'h5: zrun_len = `DVAM_ZRUN_5;
            3'h6: zrun_len = `DVAM_ZRUN_6;
            default: zrun_len = `DVAM_ZRUN_7;
        endcase
    endfunction : zrun_len

    // Step size in half-dB codes for a step field (4, 2, 1, 0.5 dB)
    function automatic logic [7:0] step_codes(input logic [1:0] s);
        case (s)
            2'h0: step_codes = 8'h08;
            2'h1: step_codes = 8'h04;
            2'h2: step_codes = 8'h02;
            default: step_codes = 8'h01;
        endcase
    endfunction : step_codes

    // Update period in samples minus one (1, 2, 4)
    function automatic logic [1:0] period_m1(input logic [1:0] f);
        case (f)
            2'h1: period_m1 = 2'h1;
            2'h2: period_m1 = 2'h3;
            default: period_m1 = 2'h0;
        endcase
    endfunction : period_m1

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        dvam_ramp_e st;
        logic [19:0] zcnt;
        logic amute;
        logic [1:0] pcnt;
        logic [7:0] gain;
    } dvam_ch_s;
    dvam_ch_s s_r; // Registered state
    dvam_ch_s s_nxt; // Next state

    logic mute_req; // Either soft mute or auto mute
    logic [8:0] sum; // Widened gain arithmetic
    logic [7:0] st_c; // Current step in codes
    dvam_ramp_e st_e; // State after a change of request
    logic [1:0] pc_e; // Period count after a change of request

    //------------------------------------------------------------
    // Next-state logic, advanced once per sample
    //------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        mute_req = soft_mute_in | s_r.amute;
        sum = 9'h000;
        st_c = 8'h00;
        st_e = s_r.st;
        pc_e = s_r.pcnt;
        if (fs_tick_in) begin
            // Zero-run counter saturates at one below the selected length
            if (!zero_in) begin
                s_nxt.zcnt = 20'h00000;
                s_nxt.amute = 1'b0;
            end else if (s_r.zcnt >= zrun_len(zrun_sel_in) - 20'h00001) begin
                s_nxt.amute = 1'b1; // R1 R2 R3
            end else begin
                s_nxt.zcnt = s_r.zcnt + 20'h00001; // R3
            end
            // A new request turns the ramp round on this same sample, so an
            // instant setting acts at once rather than one sample late
            if (mute_req && (s_r.st == DVAM_ST_RUN || s_r.st == DVAM_ST_UP)) begin
                st_e = DVAM_ST_DOWN;
                pc_e = 2'h0;
            end else if (!mute_req && (s_r.st == DVAM_ST_DOWN || s_r.st == DVAM_ST_MUTED)) begin
                st_e = DVAM_ST_UP;
                pc_e = 2'h0;
            end
            s_nxt.st = st_e;
            s_nxt.pcnt = pc_e;
            case (st_e)
                DVAM_ST_RUN: begin
                    s_nxt.gain = target_in; // R4 R5 R6 R7
                end
                DVAM_ST_UP: begin
                    if (ramp_in[3:2] == `DVAM_RATE_INSTANT || s_r.gain <= target_in) begin
                        s_nxt.gain = target_in; // R11
                        s_nxt.st = DVAM_ST_RUN;
                    end else if (pc_e != 2'h0) begin
                        s_nxt.pcnt = pc_e - 2'h1; // R11
                    end else begin
                        // Gain rises as code falls
                        st_c = step_codes(ramp_in[1:0]);
                        s_nxt.pcnt = period_m1(ramp_in[3:2]); // R11
                        if (s_r.gain - target_in <= st_c) begin
                            s_nxt.gain = target_in;
                            s_nxt.st = DVAM_ST_RUN;
                        end else begin
                            s_nxt.gain = s_r.gain - st_c;
                        end
                    end
                end
                DVAM_ST_DOWN: begin
                    if (ramp_in[7:6] == `DVAM_RATE_INSTANT) begin
                        s_nxt.gain = `DVAM_VOL_MUTE; // R9
                        s_nxt.st = DVAM_ST_MUTED;
                    end else if (pc_e != 2'h0) begin
                        s_nxt.pcnt = pc_e - 2'h1; // R9
                    end else begin
                        st_c = step_codes(ramp_in[5:4]); // R10
                        sum = {1'b0, s_r.gain} + {1'b0, st_c};
                        s_nxt.pcnt = period_m1(ramp_in[7:6]); // R9
                        if (sum >= {1'b0, `DVAM_VOL_MIN}) begin
                            s_nxt.gain = `DVAM_VOL_MUTE; // R8
                            s_nxt.st = DVAM_ST_MUTED;
                        end else begin
                            s_nxt.gain = sum[7:0]; // R10
                        end
                    end
                end
                DVAM_ST_MUTED: begin
                    s_nxt.gain = `DVAM_VOL_MUTE; // R8
                end
                default: s_nxt.st = DVAM_ST_RUN;
            endcase
        end
    end

    //------------------------------------------------------------
    // State register
    //------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '{st: DVAM_ST_RUN, zcnt: 20'h00000, amute: 1'b0, pcnt: 2'h0,
                     gain: `DVAM_RST_VOL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign gain_out = s_r.gain;
    assign auto_muted_out = s_r.amute;
endmodule : dvam_chan

// ===== hw/dvam_top.sv
// Register bank for digital volume, link, ramp control and zero-data auto-mute
`include "dvam_params.svh"
// Five control registers, a filtered soft-mute pin
// and two identical channel ramps
module dvam_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,

    // Register access and samples, same clock
    input wire dvam_pkg::dvam_req_s req_in,
    input wire dvam_pkg::dvam_smp_s smp_in,

    // Soft-mute pin, low mutes, asynchronous
    input wire logic soft_mute_pin_n_in,

    // Read data, held until the next read
    output logic [7:0] rdata_out,

    // Live gain codes
    output logic [7:0] left_gain_out,
    output logic [7:0] right_gain_out,

    // Zero-run auto-mute reached
    output logic left_auto_muted_out,
    output logic right_auto_muted_out
);
    import dvam_pkg::*;

    //------------------------------------------------------------
    // Register state
    //------------------------------------------------------------
    // All bank state in one struct: one process
    // computes it, one registers it
    typedef struct packed {
        // Mute times: left 6-4, right 2-0
        logic [7:0] amt;
        // Link mode in bits 1-0
        logic [7:0] link;
        // Gain codes, kept even while linked
        logic [7:0] lvol;
        logic [7:0] rvol;
        // Ramp rates and steps
        logic [7:0] ramp;
        // Read data, straight from a flop
        logic [7:0] rdata;
        // Pin stages, newest in bit 0
        logic [2:0] mute_sync;
    } dvam_regs_s;
    dvam_regs_s r_r; // Registered state
    dvam_regs_s r_nxt; // Next state

    // Channel side
    logic [7:0] right_target; // Code the right channel steers toward
    logic [7:0] lgain; // Left live gain
    logic [7:0] rgain; // Right live gain
    logic lam; // Left auto-muted
    logic ram; // Right auto-muted
    logic soft_mute; // Filtered soft-mute request

    // Output stage
    logic [7:0] out_lg_r;
    logic [7:0] out_rg_r;
    logic out_lam_r;
    logic out_ram_r;

    //------------------------------------------------------------
    // Register access and pin filter
    //------------------------------------------------------------
    // Pin is asynchronous: three stages, accepted when last two agree
    // A read in the cycle of a write to the
    // same place returns the old value
    always_comb begin
        // Hold all but the pin stages unless a strobe says otherwise
        r_nxt = r_r;
        // Pin taken inverted: high stage means mute
        r_nxt.mute_sync = {r_r.mute_sync[1:0], ~soft_mute_pin_n_in};

        // Writes; reserved bits stored as zero
        if (req_in.wr) begin
            case (req_in.addr)
                `DVAM_OFS_AMT: r_nxt.amt = req_in.wdata & `DVAM_AMT_MASK;
                `DVAM_OFS_LINK: r_nxt.link = req_in.wdata & `DVAM_LINK_MASK;
                `DVAM_OFS_LVOL: r_nxt.lvol = req_in.wdata; // R6
                `DVAM_OFS_RVOL: r_nxt.rvol = req_in.wdata; // R12
                `DVAM_OFS_RAMP: r_nxt.ramp = req_in.wdata;
                default: r_nxt.amt = r_r.amt; // Unmapped write ignored
            endcase
        end

        // Reads answer one cycle after the strobe
        if (req_in.rd) begin
            case (req_in.addr)
                `DVAM_OFS_AMT: r_nxt.rdata = r_r.amt;
                `DVAM_OFS_LINK: r_nxt.rdata = r_r.link;
                `DVAM_OFS_LVOL: r_nxt.rdata = r_r.lvol;
                `DVAM_OFS_RVOL: r_nxt.rdata = r_r.rvol;
                `DVAM_OFS_RAMP: r_nxt.rdata = r_r.ramp;
                default: r_nxt.rdata = 8'h00; // Unmapped reads as zero
            endcase
        end
    end

    // Register file; reset loads power-on codes
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            r_r <= '{
                amt: `DVAM_RST_AMT,
                link: `DVAM_RST_LINK,
                lvol: `DVAM_RST_VOL,
                rvol: `DVAM_RST_VOL,
                ramp: `DVAM_RST_RAMP,
                rdata: 8'h00,
                mute_sync: 3'h0
            };
        end else begin
            r_r <= r_nxt;
        end
    end

    // Hold last accepted pin level until stages two and three agree
    // A one-cycle glitch never reaches the ramps
    logic soft_mute_r; // Accepted soft-mute level
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            // Pin idle level: no false mute after reset
            soft_mute_r <= 1'b0;
        end else if (r_r.mute_sync[1] == r_r.mute_sync[2]) begin
            // Stages agree: accept the level
            soft_mute_r <= r_r.mute_sync[2];
        end
    end
    // Both channels ramp from their own gain
    assign soft_mute = soft_mute_r;

    //------------------------------------------------------------
    // Link selection
    //------------------------------------------------------------
    // Other link codes treated as independent; right code is kept meanwhile
    // Linking steers only the target; zero
    // detection stays per channel
    always_comb begin
        if (r_r.link[1:0] == `DVAM_LINK_FOLLOW) begin
            // Right tracks the left code
            right_target = r_r.lvol; // R5 R12
        end else begin
            // Right uses its own code
            right_target = r_r.rvol; // R4
        end
    end

    //------------------------------------------------------------
    // Channels
    //------------------------------------------------------------
    // Left: own zero detector and ramp
    dvam_chan u_left (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .fs_tick_in(smp_in.valid),
        .zero_in(smp_in.left == 24'h000000),
        .soft_mute_in(soft_mute),
        .zrun_sel_in(r_r.amt[`DVAM_LEFT_ZERO_MUTE_TIME_LSB +: 3]), // R1
        .target_in(r_r.lvol),
        .ramp_in(r_r.ramp),
        .gain_out(lgain),
        .auto_muted_out(lam)
    );

    // Right: target from link selection
    // Ramp settings and soft mute are shared
    dvam_chan u_right (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .fs_tick_in(smp_in.valid),
        .zero_in(smp_in.right == 24'h000000),
        .soft_mute_in(soft_mute),
        .zrun_sel_in(r_r.amt[`DVAM_RIGHT_ZERO_MUTE_TIME_LSB +: 3]), // R2
        .target_in(right_target), // R7
        .ramp_in(r_r.ramp),
        .gain_out(rgain),
        .auto_muted_out(ram)
    );

    //------------------------------------------------------------
    // Output registers
    //------------------------------------------------------------
    // Outputs leave from flops; one cycle of
    // latency is tiny against a sample period
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            // Reset codes while reset is held
            out_lg_r <= `DVAM_RST_VOL;
            out_rg_r <= `DVAM_RST_VOL;
            out_lam_r <= 1'b0;
            out_ram_r <= 1'b0;
        end else begin
            // Copy the channel results
            // Flags lag like the gains
            out_lg_r <= lgain;
            out_rg_r <= rgain;
            out_lam_r <= lam;
            out_ram_r <= ram;
        end
    end


    // Ports driven from the registers
    // Read data straight from the bank
    assign rdata_out = r_r.rdata;
    assign left_gain_out = out_lg_r;
    assign right_gain_out = out_rg_r;
    assign left_auto_muted_out = out_lam_r;
    assign right_auto_muted_out = out_ram_r;
endmodule : dvam_top

// ===== verif/dvam_top_asserts.sv
// Port-level checker for the volume and auto-mute register block
`include "dvam_params.svh"
module dvam_top_asserts (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire dvam_pkg::dvam_req_s req_in,
    input wire dvam_pkg::dvam_smp_s smp_in,
    input wire logic soft_mute_pin_n_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] left_gain_out,
    input wire logic [7:0] right_gain_out,
    input wire logic left_auto_muted_out,
    input wire logic right_auto_muted_out
);
    import dvam_pkg::*;
    //------------------------------------------------------------
    // Shadow of the mute-time register and zero-run counters
    //------------------------------------------------------------
    localparam logic [19:0] ZLEN [8] = '{`DVAM_ZRUN_0, `DVAM_ZRUN_1, `DVAM_ZRUN_2,
        `DVAM_ZRUN_3, `DVAM_ZRUN_4, `DVAM_ZRUN_5, `DVAM_ZRUN_6, `DVAM_ZRUN_7};
    logic [7:0] amt_r; // Copy of written mute-time selections
    logic [19:0] zl_r; // Consecutive zero left samples
    logic [19:0] zr_r; // Consecutive zero right samples
    // One process keeps all helper state; a non-zero sample restarts a run
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            amt_r <= `DVAM_RST_AMT;
            zl_r <= 20'h00000;
            zr_r <= 20'h00000;
        end else begin
            if (req_in.wr && req_in.addr == `DVAM_OFS_AMT) begin
                amt_r <= req_in.wdata;
            end
            if (smp_in.valid) begin
                zl_r <= (smp_in.left == 24'h000000) ? zl_r + 20'h00001 : 20'h00000;
                zr_r <= (smp_in.right == 24'h000000) ? zr_r + 20'h00001 : 20'h00000;
            end
        end
    end
    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    amt_mask_a: assert property (req_in.rd && req_in.addr == `DVAM_OFS_AMT |=>
        (rdata_out & 8'h88) == 8'h00) else $error("mute-time reserved bits read back set");
    link_mask_a: assert property (req_in.rd && req_in.addr == `DVAM_OFS_LINK |=>
        rdata_out[7:2] == 6'h00) else $error("link reserved bits read back set");
    left_readback_a: assert property (req_in.wr && req_in.addr == `DVAM_OFS_LVOL ##2
        (req_in.rd && !req_in.wr && req_in.addr == `DVAM_OFS_LVOL)
        |=> rdata_out == $past(req_in.wdata, 3)) else $error("left code read back wrong");
    right_store_a: assert property (req_in.wr && req_in.addr == `DVAM_OFS_RVOL ##2
        (req_in.rd && !req_in.wr && req_in.addr == `DVAM_OFS_RVOL)
        |=> rdata_out == $past(req_in.wdata, 3)) else $error("right code not stored");
    left_gain_time_a: assert property ($changed(left_gain_out) |->
        $past(smp_in.valid, 2) || $past(smp_in.valid, 3)) else $error("left gain moved off fs");
    right_gain_time_a: assert property ($changed(right_gain_out) |->
        $past(smp_in.valid, 2) || $past(smp_in.valid, 3)) else $error("right gain moved off fs");
    left_zero_run_a: assert property ($rose(left_auto_muted_out) |->
        zl_r >= ZLEN[amt_r[6:4]]) else $error("left auto-mute before run length");
    right_zero_run_a: assert property ($rose(right_auto_muted_out) |->
        zr_r >= ZLEN[amt_r[2:0]]) else $error("right auto-mute before run length");
    left_mute_clear_a: assert property (smp_in.valid && smp_in.left != 24'h000000 |->
        ##[1:3] !left_auto_muted_out) else $error("left auto-mute not cleared");
    // Main scenarios reached
    cover property ($rose(left_auto_muted_out));
    cover property ($fell(soft_mute_pin_n_in));
    cover property (left_gain_out == `DVAM_VOL_MUTE);
endmodule : dvam_top_asserts

bind dvam_top dvam_top_asserts u_dvam_top_asserts (.clk_in(clk_in), .rst_in(rst_in),
    .req_in(req_in), .smp_in(smp_in), .soft_mute_pin_n_in(soft_mute_pin_n_in),
    .rdata_out(rdata_out), .left_gain_out(left_gain_out), .right_gain_out(right_gain_out),
    .left_auto_muted_out(left_auto_muted_out), .right_auto_muted_out(right_auto_muted_out));

// ===== verif/test_dvam_top.sv
// Self-checking bench for the volume and auto-mute register block
`include "dvam_params.svh"
module test_dvam_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dvam_pkg::*;
    //------------------------------------------------------------
    // Stimulus, results and bookkeeping
    //------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    dvam_req_s req_in = '0;
    dvam_smp_s smp_in = '0;
    logic soft_mute_pin_n_in = 1'b1; // Pin idles high: not muted
    logic [7:0] rdata_out;
    logic [7:0] left_gain_out;
    logic [7:0] right_gain_out;
    logic left_auto_muted_out;
    logic right_auto_muted_out;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] rofs [5] = '{8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
    logic [7:0] rrst [5] = '{8'h00, 8'h00, 8'h30, 8'h30, 8'h33};
    logic [7:0] tl [2] = '{8'h00, 8'hFF}; // Left codes: top of scale, mute
    logic [7:0] tr [2] = '{8'hFE, 8'h31}; // Right codes: floor, one step down
    dvam_top u_dvam_top (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .smp_in(smp_in),
        .soft_mute_pin_n_in(soft_mute_pin_n_in), .rdata_out(rdata_out),
        .left_gain_out(left_gain_out), .right_gain_out(right_gain_out),
        .left_auto_muted_out(left_auto_muted_out), .right_auto_muted_out(right_auto_muted_out));
    // 250 MHz clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    //------------------------------------------------------------
    // Compare, access and closing tasks
    //------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask : chk1
    // Request is held across exactly one rising edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_in);
        req_in = '0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_in);
        req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_in);
        req_in = '0;
        chk8(rdata_out, e, "read data");
    endtask : rd_reg
    // One stereo sample, then n idle half-way points to let the gain settle
    task automatic smp(input logic [23:0] l, input logic [23:0] r, input int n);
        @(negedge clk_in);
        smp_in = '{valid: 1'b1, left: l, right: r};
        @(negedge clk_in);
        smp_in.valid = 1'b0;
        repeat (n) @(negedge clk_in);
    endtask : smp
    task automatic gains(input logic [7:0] el, input logic [7:0] er);
        smp(24'h000100, 24'h000100, 2);
        chk8(left_gain_out, el, "left gain");
        chk8(right_gain_out, er, "right gain");
    endtask : gains
    // Pin passes a three-flop synchroniser, so allow it to settle
    task automatic pin(input logic v);
        @(negedge clk_in);
        soft_mute_pin_n_in = v;
        repeat (6) @(negedge clk_in);
    endtask : pin
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // Hang guard: the run needs about 10300 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            $display("unexpected at %0t: timeout", $time);
            report_and_stop();
        end
    end
    //------------------------------------------------------------
    // Test sequence
    //------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        chk8(left_gain_out, 8'h30, "left gain");
        chk8(right_gain_out, 8'h30, "right gain");
        for (int i = 0; i < 5; i++) begin
            rd_reg(rofs[i], rrst[i]);
        end
        $display("test reset values done");
        // Reserved bits drop, unmapped place reads zero
        wr_reg(8'h3B, 8'hFF);
        rd_reg(8'h3B, 8'h77);
        wr_reg(8'h3C, 8'hFF);
        rd_reg(8'h3C, 8'h03);
        wr_reg(8'h40, 8'h55);
        rd_reg(8'h40, 8'h00);
        wr_reg(8'h3C, 8'h00);
        wr_reg(8'h3B, 8'h00);
        $display("test register fields done");
        for (int i = 0; i < 2; i++) begin
            wr_reg(8'h3D, tl[i]);
            rd_reg(8'h3D, tl[i]);
            wr_reg(8'h3E, tr[i]);
            rd_reg(8'h3E, tr[i]);
            gains(tl[i], tr[i]);
        end
        $display("test gain codes done");
        wr_reg(8'h3C, 8'h01);
        wr_reg(8'h3D, 8'h20);
        wr_reg(8'h3E, 8'h10);
        rd_reg(8'h3E, 8'h10);
        gains(8'h20, 8'h20);
        rd_reg(8'h3E, 8'h10);
        wr_reg(8'h3C, 8'h00);
        gains(8'h20, 8'h10);
        $display("test volume link done");
        // Ramp down 4 dB per sample, instant restore
        wr_reg(8'h3D, 8'h30);
        wr_reg(8'h3E, 8'h30);
        gains(8'h30, 8'h30);
        wr_reg(8'h3F, 8'h0F);
        pin(1'b0);
        for (int i = 0; i < 4 && left_gain_out === 8'h30; i++) begin
            smp(24'h000100, 24'h000100, 2);
        end
        chk8(left_gain_out, 8'h38, "left ramp");
        gains(8'h40, 8'h40);
        pin(1'b1);
        gains(8'h30, 8'h30);
        wr_reg(8'h3F, 8'hCC);
        pin(1'b0);
        gains(8'hFF, 8'hFF);
        pin(1'b1);
        gains(8'h30, 8'h30);
        $display("test soft ramps done");
        // Shortest left run, second right run, counted in samples
        wr_reg(8'h3B, 8'h01);
        repeat (`DVAM_ZRUN_0 - 1) smp(24'h000000, 24'h000000, 0);
        smp(24'h000000, 24'h000000, 0);
        repeat (3) @(negedge clk_in);
        chk1(left_auto_muted_out, 1'b1, "left auto-mute");
        chk1(right_auto_muted_out, 1'b0, "right auto-mute");
        repeat (`DVAM_ZRUN_1 - `DVAM_ZRUN_0 - 1) smp(24'h000000, 24'h000000, 0);
        repeat (3) @(negedge clk_in);
        chk1(right_auto_muted_out, 1'b0, "right auto-mute");
        smp(24'h000000, 24'h000000, 3);
        chk1(right_auto_muted_out, 1'b1, "right auto-mute");
        smp(24'h000000, 24'h000000, 3);
        chk8(left_gain_out, 8'hFF, "left muted gain");
        smp(24'h000100, 24'h000000, 3);
        chk1(left_auto_muted_out, 1'b0, "left auto-mute");
        chk1(right_auto_muted_out, 1'b1, "right auto-mute");
        $display("test auto mute done");
        report_and_stop();
    end
endmodule : test_dvam_top
